// [verilog/nvs_defs.vh]
`ifndef NVS_DEFS_VH
`define NVS_DEFS_VH
// device address word type code, upper four bits
`define NVS_TYPE_CODE 4'hA
// high-speed master code, upper five bits
`define NVS_HS_CODE 5'h01
// reserved slave identifier for sleep and other special sequences
`define NVS_RSV_ID 8'hF8
// sleep command byte
`define NVS_SLEEP_CMD 8'h86
// memory address width and reset value of the address counter
`define NVS_ADDR_W 16
`define NVS_ADDR_RST 16'h0000
// regulator recovery time in ns, and the 20 MHz clock period in ns
`define NVS_REC_NS 400000
`define NVS_CLK_NS 50
// recovery count in cycles, least time rounded up
`define NVS_REC_CYC ((`NVS_REC_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
// ninth clock of a byte-plus-acknowledge slot
`define NVS_ACK_BIT 4'h8
`endif

// [verilog/nvs_fifo.v]
`timescale 1ns/1ns
// small synchronous fifo, read data held in a register
module nvs_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_i, // clock
   input wire rst_i, // async reset, active high
   input wire [WIDTH-1:0] wr_data_i, // write data
   input wire wr_valid_i, // write request
   output wire wr_ready_o, // room available
   output reg [WIDTH-1:0] rd_data_o, // head word, registered
   output reg rd_valid_o, // head word valid
   input wire rd_ready_i, // consumer takes head
   input wire flush_i // drop all contents
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire [AW:0] count;
   wire full;
   wire empty;
   wire do_wr;
   wire do_rd;
   assign count = wr_ptr - rd_ptr;
   assign full = (count == DEPTH[AW:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign wr_ready_o = ~full;
   assign do_wr = wr_valid_i & ~full;
   // load the output register when it is free or being taken
   assign do_rd = ~empty & (~rd_valid_o | rd_ready_i);
   // storage has no reset; only pointers and the output register need defined values
   always @(posedge clk_i) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= wr_data_i;
      end
   end
   // pointers and output register
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
         rd_data_o <= {WIDTH{1'b0}};
         rd_valid_o <= 1'b0;
      end else if (flush_i) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
         rd_valid_o <= 1'b0;
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_data_o <= mem[rd_ptr[AW-1:0]];
            rd_ptr <= rd_ptr + 1'b1;
            rd_valid_o <= 1'b1;
         end else if (rd_ready_i) begin
            rd_valid_o <= 1'b0;
         end
      end
   end
endmodule

// [verilog/nvs_slave.v]
`timescale 1ns/1ns
`include "nvs_defs.vh"
// Notes on behaviour
// - read direction returns successive bytes while master acknowledges each one
// - read address wraps from last location to zero without a pause
// - device leaves the high-speed master code unacknowledged, sda released
// - after that code transfers continue at up to 3.4 MHz
// - stop ends high-speed mode; new master code needed afterwards
// - in high speed, repeated start then any normal command follows
// - address word follows, direction ignored; matching device acknowledges
// - device acknowledges 86h then sleeps with regulators off
// - asleep, device still watches sda and scl for wake-up
// - recovery begins on rising scl of ninth clock after start
// - standby returns only after recovery time; master waits
// - back in standby, commands resume, each after a fresh start
// - respond only to type 1010 with select bits equal to select pins
// - device drives eight bits, then releases sda for master acknowledge
// - direction bit 0 selects write, 1 selects read
module nvs_slave #(
   parameter REC_CYCLES = `NVS_REC_CYC, // regulator_recovery_time in clocks
   parameter FIFO_DEPTH = 16 // write data buffer depth
) (
   input wire sys_clk_i, // 20 MHz system clock
   input wire rst_i, // power-on reset, async, active high
   input wire scl_i, // bus clock pin
   input wire sda_i, // bus data pin level
   output reg sda_o, // data drive value, always low when enabled
   output reg sda_oe_n_o, // low while the device pulls sda
   input wire select_pin_bit2_i, // select pin 2
   input wire select_pin_bit1_i, // select pin 1
   input wire select_pin_bit0_i, // select pin 0
   output reg [`NVS_ADDR_W-1:0] mem_addr_o, // memory address
   output reg mem_rd_o, // memory read strobe, one cycle
   input wire [7:0] mem_rdata_i, // read data, valid cycle after strobe
   output reg mem_wr_o, // memory write strobe, one cycle
   output reg [7:0] mem_wdata_o, // memory write data
   input wire mem_wr_ready_i, // memory can take a write
   output reg hs_mode_o, // high-speed mode active
   output reg sleep_o, // regulators off
   output reg rec_busy_o // recovery in progress
);
   localparam ST_IDLE = 8'h01; // waiting for start
   localparam ST_DEV = 8'h02; // receiving first byte
   localparam ST_AHI = 8'h04; // address high byte
   localparam ST_ALO = 8'h08; // address low byte
   localparam ST_WDAT = 8'h10; // write data bytes
   localparam ST_RDAT = 8'h20; // read data bytes
   localparam ST_SLPA = 8'h40; // address word after reserved id
   localparam ST_SLPC = 8'h80; // expecting sleep command
   // two-flop synchronisers for pins
   reg [1:0] scl_sy;
   reg [1:0] sda_sy;
   reg scl_d;
   reg sda_d;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   reg [7:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shreg;
   reg ack_pend; // we acknowledge the current ninth bit
   reg slp_pend; // enter sleep when ack slot ends
   reg rd_nack; // master refused further read data
   reg [7:0] tx_byte;
   reg [`NVS_ADDR_W-1:0] addr;
   reg [22:0] rec_cnt;
   reg wake_seen; // start seen while asleep
   reg rd_wait; // read data due one cycle later
   reg [2:0] sel_sy1; // select straps, first stage
   reg [2:0] sel_sy2; // select straps, settled
   wire [7:0] rx_byte;
   wire dev_match;
   wire [7:0] fifo_q;
   wire fifo_v;
   wire fifo_rdy;
   reg fifo_push;
   assign scl_rise = scl_sy[1] & ~scl_d;
   assign scl_fall = ~scl_sy[1] & scl_d;
   assign start_det = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
   assign stop_det = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];
   assign rx_byte = {shreg[6:0], sda_sy[1]};
   // type code and select pins checked on the shifted byte
   assign dev_match = (rx_byte[7:4] == `NVS_TYPE_CODE) &&
      (rx_byte[3:1] == sel_sy2);
   // write data buffered so a slow array can lag; a byte arriving at a full buffer is nacked and not stored
   nvs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(4)) u_wbuf (
      .clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_data_i(shreg), // whole byte sits in shreg on the push cycle
      .wr_valid_i(fifo_push),
      .wr_ready_o(fifo_rdy),
      .rd_data_o(fifo_q),
      .rd_valid_o(fifo_v),
      .rd_ready_i(mem_wr_ready_i),
      .flush_i(1'b0)
   );
   // pin sampling
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_sy <= {scl_sy[0], scl_i};
         sda_sy <= {sda_sy[0], sda_i};
         scl_d <= scl_sy[1];
         sda_d <= sda_sy[1];
      end
   end
   // select straps are pins as well, so they pass two flops before the match
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_sy1 <= 3'h0;
         sel_sy2 <= 3'h0;
      end else begin
         sel_sy1 <= {select_pin_bit2_i, select_pin_bit1_i, select_pin_bit0_i};
         sel_sy2 <= sel_sy1;
      end
   end
   // array write port drains the buffer
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_wr_o <= 1'b0;
         mem_wdata_o <= 8'h00;
      end else begin
         mem_wr_o <= fifo_v & mem_wr_ready_i;
         mem_wdata_o <= fifo_q;
      end
   end
   // bus protocol engine
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         ack_pend <= 1'b0;
         slp_pend <= 1'b0;
         rd_nack <= 1'b0;
         tx_byte <= 8'h00;
         addr <= `NVS_ADDR_RST;
         mem_addr_o <= `NVS_ADDR_RST;
         mem_rd_o <= 1'b0;
         rd_wait <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_n_o <= 1'b1;
         hs_mode_o <= 1'b0;
         sleep_o <= 1'b0;
         rec_busy_o <= 1'b0;
         rec_cnt <= 23'h000000;
         wake_seen <= 1'b0;
         fifo_push <= 1'b0;
      end else begin
         mem_rd_o <= 1'b0;
         fifo_push <= 1'b0;
         rd_wait <= mem_rd_o;
         if (rd_wait) begin
            tx_byte <= mem_rdata_i;
         end
         if (rec_busy_o) begin
            // bus ignored until the regulator has recovered
            if (rec_cnt == 23'h000001) begin
               rec_busy_o <= 1'b0;
               state <= ST_IDLE;
            end
            rec_cnt <= rec_cnt - 1'b1;
         end else if (sleep_o) begin
            // only the wake-up sequence is watched while asleep
            if (start_det) begin
               wake_seen <= 1'b1;
               bit_cnt <= 4'h0;
            end else if (stop_det) begin
               wake_seen <= 1'b0;
            end else if (wake_seen && scl_rise) begin
               bit_cnt <= bit_cnt + 1'b1;
               if (bit_cnt == `NVS_ACK_BIT) begin
                  // direction bit ignored, any address word wakes
                  sleep_o <= 1'b0;
                  rec_busy_o <= 1'b1;
                  rec_cnt <= REC_CYCLES[22:0];
                  wake_seen <= 1'b0;
                  bit_cnt <= 4'h0;
               end
            end
         end else if (stop_det) begin
            state <= ST_IDLE;
            sda_oe_n_o <= 1'b1;
            hs_mode_o <= 1'b0;
            ack_pend <= 1'b0;
         end else if (start_det) begin
            // repeated start keeps hs mode and the address counter
            state <= ST_DEV;
            bit_cnt <= 4'h0;
            sda_oe_n_o <= 1'b1;
            ack_pend <= 1'b0;
         end else if (scl_rise && state != ST_IDLE) begin
            if (bit_cnt == `NVS_ACK_BIT) begin
               rd_nack <= sda_sy[1];
            end else begin
               shreg <= rx_byte;
            end
            if (bit_cnt == 4'h7 && state != ST_RDAT) begin
               // byte complete on eighth rising edge
               ack_pend <= 1'b0;
               case (state)
                  ST_DEV: begin
                     if (rx_byte[7:3] == `NVS_HS_CODE) begin
                        hs_mode_o <= 1'b1;
                        state <= ST_IDLE;
                     end else if (rx_byte == `NVS_RSV_ID) begin
                        ack_pend <= 1'b1;
                        state <= ST_SLPA;
                     end else if (rx_byte == `NVS_SLEEP_CMD && state == ST_DEV && slp_pend) begin
                        // the repeated start left ST_SLPC; go back so the ack slot ends in sleep
                        ack_pend <= 1'b1;
                        state <= ST_SLPC;
                     end else if (dev_match) begin
                        ack_pend <= 1'b1;
                        slp_pend <= 1'b0;
                        if (rx_byte[0]) begin
                           state <= ST_RDAT;
                           mem_addr_o <= addr;
                           mem_rd_o <= 1'b1;
                        end else begin
                           state <= ST_AHI;
                        end
                     end else begin
                        state <= ST_IDLE;
                        slp_pend <= 1'b0;
                     end
                  end
                  ST_SLPA: begin
                     ack_pend <= dev_match;
                     slp_pend <= dev_match;
                     state <= dev_match ? ST_SLPC : ST_IDLE;
                  end
                  ST_AHI: begin
                     ack_pend <= 1'b1;
                     addr[15:8] <= rx_byte;
                     state <= ST_ALO;
                  end
                  ST_ALO: begin
                     ack_pend <= 1'b1;
                     addr[7:0] <= rx_byte;
                     state <= ST_WDAT;
                  end
                  ST_WDAT: begin
                     // full buffer refuses the byte with a nack
                     ack_pend <= fifo_rdy;
                     fifo_push <= fifo_rdy;
                     addr <= addr + 1'b1;
                  end
                  default: begin
                     state <= ST_IDLE;
                  end
               endcase
            end
            bit_cnt <= (bit_cnt == `NVS_ACK_BIT) ? 4'h0 : bit_cnt + 1'b1;
         end else if (scl_fall) begin
            // sda changes only while scl is low
            if (state == ST_RDAT) begin
               if (bit_cnt == `NVS_ACK_BIT) begin
                  // address word ack on entry, later slots released for the master's ack
                  sda_oe_n_o <= ~ack_pend;
                  ack_pend <= 1'b0;
               end else if (bit_cnt == 4'h0 && rd_nack) begin
                  sda_oe_n_o <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  sda_oe_n_o <= tx_byte[3'h7 - bit_cnt[2:0]];
                  if (bit_cnt == 4'h7) begin
                     addr <= addr + 1'b1;
                     mem_addr_o <= addr + 1'b1;
                     mem_rd_o <= 1'b1;
                  end
               end
            end else if (bit_cnt == `NVS_ACK_BIT && ack_pend) begin
               sda_oe_n_o <= 1'b0;
            end else begin
               sda_oe_n_o <= 1'b1;
               if (slp_pend && ack_pend == 1'b0 && state == ST_SLPC && bit_cnt == 4'h0) begin
                  state <= ST_SLPC;
               end
               if (bit_cnt == 4'h0 && ack_pend && state == ST_SLPC && shreg == `NVS_SLEEP_CMD) begin
                  sleep_o <= 1'b1;
                  slp_pend <= 1'b0;
                  hs_mode_o <= 1'b0;
                  state <= ST_IDLE;
               end
               if (bit_cnt == 4'h0) begin
                  ack_pend <= 1'b0;
               end
            end
            rd_nack <= (bit_cnt == 4'h0) ? 1'b0 : rd_nack;
         end
      end
   end
endmodule

// [tb/nvs_i2c_master.sv]
`timescale 1ns/1ns
// bus master model: scl low 5 clocks, high 3 clocks, 400 ns a bit
module nvs_i2c_master (
   input wire logic clk_i, // paces the bus
   input wire logic sda_i, // resolved sda level
   output logic scl_o, // bus clock, only ever driven here
   output logic sda_oe_n_o // low while the master pulls sda
);
   // idle bus: clock high, data left to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_oe_n_o = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // data changes mid low phase; slave answer sampled late in high phase
   task automatic bit_x(input logic b, output logic r);
      cyc(2);
      sda_oe_n_o <= b;
      cyc(3);
      scl_o <= 1'b1;
      cyc(2);
      r = sda_i;
      cyc(1);
      scl_o <= 1'b0;
   endtask
   // long low phase first, so a slave ack is released before sda rises
   task automatic start();
      cyc(2);
      sda_oe_n_o <= 1'b1;
      cyc(5);
      scl_o <= 1'b1;
      cyc(3);
      sda_oe_n_o <= 1'b0;
      cyc(3);
      scl_o <= 1'b0;
   endtask
   task automatic stop();
      cyc(2);
      sda_oe_n_o <= 1'b0;
      cyc(3);
      scl_o <= 1'b1;
      cyc(3);
      sda_oe_n_o <= 1'b1;
      cyc(5);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   // last byte left unacknowledged to end the read
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(last, r);
   endtask
endmodule

// [tb/nvs_slave_properties.sv]
`timescale 1ns/1ns
`include "nvs_defs.vh"
module nvs_slave_properties #(
   parameter REC_CYCLES = `NVS_REC_CYC,
   parameter FIFO_DEPTH = 16
) (
   input wire sys_clk_i, // clock
   input wire rst_i, // async reset
   input wire scl_i, // bus clock pin
   input wire sda_i, // bus data pin
   input wire sda_o, // drive value
   input wire sda_oe_n_o, // drive enable, low active
   input wire [`NVS_ADDR_W-1:0] mem_addr_o, // memory address
   input wire mem_rd_o, // read strobe
   input wire mem_wr_o, // write strobe
   input wire hs_mode_o, // high-speed mode
   input wire sleep_o, // asleep
   input wire rec_busy_o // recovering
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // length of the running recovery, in clocks
   reg [31:0] rec_cnt;
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rec_cnt <= 32'h0;
      end else begin
         rec_cnt <= rec_busy_o ? rec_cnt + 32'h1 : 32'h0;
      end
   end
   // raw pins: stop is sda rising while scl high
   sequence s_stop;
      scl_i && $rose(sda_i);
   endsequence
   // the whole acknowledge slot left released
   sequence s_quiet;
      sda_oe_n_o [*8];
   endsequence
   property p_drive_low;
      !sda_oe_n_o |-> !sda_o;
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("sda driven high");
   property p_hs_nack;
      $rose(hs_mode_o) |-> s_quiet;
   endproperty
   a_hs_nack: assert property (p_hs_nack) else $error("master code acknowledged");
   property p_hs_stop;
      hs_mode_o ##0 s_stop |-> ##[1:8] !hs_mode_o;
   endproperty
   a_hs_stop: assert property (p_hs_stop) else $error("high speed kept after stop");
   property p_wake;
      $fell(sleep_o) |-> rec_busy_o;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without recovery");
   property p_rec_len;
      $fell(rec_busy_o) |-> rec_cnt == REC_CYCLES;
   endproperty
   a_rec_len: assert property (p_rec_len) else $error("recovery length wrong");
   property p_rec_quiet;
      rec_busy_o |-> sda_oe_n_o && !mem_rd_o && !mem_wr_o;
   endproperty
   a_rec_quiet: assert property (p_rec_quiet) else $error("activity in recovery");
   property p_sleep_quiet;
      sleep_o |-> !mem_rd_o && !mem_wr_o;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("memory access asleep");
   property p_rd_pulse;
      mem_rd_o |=> !mem_rd_o;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
endmodule
bind nvs_slave nvs_slave_properties #(.REC_CYCLES(REC_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_nvs_slave_properties (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
   .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .hs_mode_o(hs_mode_o),
   .sleep_o(sleep_o), .rec_busy_o(rec_busy_o));

// [tb/nvs_slave_tb.sv]
`timescale 1ns/1ns
`include "nvs_defs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR %0t got %h want %h", $time, (a), (e)); end end
module nvs_slave_tb;
   localparam int REC = 20;
   localparam logic [2:0] SEL = 3'h5;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic mem_wr_ready_i = 1'b1;
   logic [7:0] mem_rdata_i = 8'h00;
   wire scl, m_oe_n, sda_w, sda_o, sda_oe_n_o, mem_rd_o, mem_wr_o, hs_mode_o, sleep_o, rec_busy_o;
   wire [15:0] mem_addr_o;
   wire [7:0] mem_wdata_o;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   int wr_cnt = 0;
   logic [7:0] wr_last = 8'h00;
   logic ack;
   logic [7:0] d;
   // open-drain wire with pull-up
   assign sda_w = m_oe_n & (sda_oe_n_o | sda_o);
   nvs_slave #(.REC_CYCLES(REC), .FIFO_DEPTH(16)) u_nvs_slave (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .select_pin_bit2_i(SEL[2]), .select_pin_bit1_i(SEL[1]),
      .select_pin_bit0_i(SEL[0]), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i),
      .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_wr_ready_i(mem_wr_ready_i),
      .hs_mode_o(hs_mode_o), .sleep_o(sleep_o), .rec_busy_o(rec_busy_o));
   nvs_i2c_master u_nvs_i2c_master (.clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(m_oe_n));
   // array contents are a fixed mix of the address bytes
   function automatic logic [7:0] fdat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction
   function automatic logic [7:0] dev(input logic rw);
      return {4'hA, SEL, rw};
   endfunction
   task automatic end_of_test();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic put(input logic [7:0] b, input logic exp);
      u_nvs_i2c_master.wr_byte(b, ack);
      `CHK(ack, exp)
   endtask
   // set address, turn round, read n bytes, last one refused
   task automatic seq_read(input logic [15:0] a, input int n);
      u_nvs_i2c_master.start();
      put(dev(1'b0), 1'b1);
      put(a[15:8], 1'b1);
      put(a[7:0], 1'b1);
      u_nvs_i2c_master.start();
      put(dev(1'b1), 1'b1);
      for (int i = 0; i < n; i++) begin
         u_nvs_i2c_master.rd_byte(i == n - 1, d);
         `CHK(d, fdat(a + i[15:0]))
      end
      u_nvs_i2c_master.stop();
      `CHK(sda_oe_n_o, 1'b1)
   endtask
   task automatic t_wrap();
      seq_read(16'hFFFE, 4);
   endtask
   // wrong type code, then wrong select bits
   task automatic t_refuse();
      u_nvs_i2c_master.start();
      put({4'h9, SEL, 1'b1}, 1'b0);
      u_nvs_i2c_master.stop();
      u_nvs_i2c_master.start();
      put({4'hA, SEL ^ 3'h1, 1'b1}, 1'b0);
      u_nvs_i2c_master.stop();
   endtask
   // direction 0 writes: one data byte must reach the array port intact
   task automatic t_write();
      u_nvs_i2c_master.start();
      put(dev(1'b0), 1'b1);
      put(8'h00, 1'b1);
      put(8'h40, 1'b1);
      put(8'h5A, 1'b1);
      u_nvs_i2c_master.stop();
      `CHK(wr_cnt, 1)
      `CHK(wr_last, 8'h5A)
   endtask
   // both ends of the don't-care low bits
   task automatic t_hs();
      for (int i = 0; i < 2; i++) begin
         u_nvs_i2c_master.start();
         put(i ? 8'h0F : 8'h08, 1'b0);
         u_nvs_i2c_master.cyc(4);
         `CHK(hs_mode_o, 1'b1)
         seq_read(16'h1234, 2);
         `CHK(hs_mode_o, 1'b0)
      end
   endtask
   task automatic t_sleep();
      int n;
      u_nvs_i2c_master.start();
      put(8'hF8, 1'b1);
      put(dev(1'b1), 1'b1);
      u_nvs_i2c_master.start();
      put(8'h86, 1'b1);
      u_nvs_i2c_master.stop();
      `CHK(sleep_o, 1'b1)
      u_nvs_i2c_master.start();
      u_nvs_i2c_master.wr_byte(dev(1'b0), ack);
      n = 0;
      while (rec_busy_o !== 1'b1 && n < 10) begin
         @(negedge sys_clk_i);
         n++;
      end
      `CHK(rec_busy_o, 1'b1)
      `CHK(sleep_o, 1'b0)
      n = 0;
      while (rec_busy_o === 1'b1 && n < 4 * REC) begin
         @(negedge sys_clk_i);
         n++;
      end
      `CHK(n >= REC - 6 && n <= REC, 1'b1)
      u_nvs_i2c_master.stop();
      seq_read(16'h0010, 2);
   endtask
   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // array read port and run limit
   always @(posedge sys_clk_i) begin
      if (mem_rd_o) mem_rdata_i <= fdat(mem_addr_o);
      // array write port: count strobes, keep the last byte
      if (mem_wr_o) begin
         wr_cnt++;
         wr_last <= mem_wdata_o;
      end
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      t_wrap();
      t_refuse();
      t_write();
      t_hs();
      t_sleep();
      end_of_test();
   end
endmodule
